/* File: hw/modulator_pkg.sv */
package modulator_pkg;

	// synchroniser depth for every asynchronous source
	localparam int SYNC_STAGES = 2;

	// data source codes
	localparam logic [3:0] DATA_SOFTWARE = 4'h0;
	localparam logic [3:0] DATA_EXT_PIN = 4'h1;
	localparam logic [3:0] DATA_CCP1 = 4'h2;
	localparam logic [3:0] DATA_CCP2 = 4'h3;
	localparam logic [3:0] DATA_PWM5 = 4'h4;
	localparam logic [3:0] DATA_PWM6 = 4'h5;
	localparam logic [3:0] DATA_CMP1 = 4'h6;
	localparam logic [3:0] DATA_CMP2 = 4'h7;
	localparam logic [3:0] DATA_SERIAL = 4'h8;
	localparam logic [3:0] DATA_UART_TX = 4'hA;
	localparam logic [3:0] DATA_NCO = 4'hB;
	localparam logic [3:0] DATA_CLC1 = 4'hC;
	localparam logic [3:0] DATA_CLC2 = 4'hD;

	// carrier source codes
	localparam logic [3:0] CARRIER_GROUND = 4'h0;
	localparam logic [3:0] CARRIER_PIN_A = 4'h1;
	localparam logic [3:0] CARRIER_PIN_B = 4'h2;
	localparam logic [3:0] CARRIER_REF_CLOCK = 4'h3;
	localparam logic [3:0] CARRIER_CCP1 = 4'h4;
	localparam logic [3:0] CARRIER_CCP2 = 4'h5;
	localparam logic [3:0] CARRIER_PWM5 = 4'h6;
	localparam logic [3:0] CARRIER_PWM6 = 4'h7;
	localparam logic [3:0] CARRIER_NCO = 4'h8;
	localparam logic [3:0] CARRIER_SYS_CLOCK = 4'hA;
	localparam logic [3:0] CARRIER_FAST_OSC = 4'hB;
	localparam logic [3:0] CARRIER_CLC1 = 4'hC;
	localparam logic [3:0] CARRIER_CLC2 = 4'hD;

	// every signal that may feed data or a carrier
	typedef struct packed {
		logic external_data_pin;
		logic external_carrier_pin_a;
		logic external_carrier_pin_b;
		logic reference_clock_output;
		logic ccp1_output;
		logic ccp2_output;
		logic pwm5_output;
		logic pwm6_output;
		logic comparator1_output;
		logic comparator2_output;
		logic serial_data_out;
		logic uart_tx_output;
		logic nco_output;
		logic clc1_output;
		logic clc2_output;
		logic system_clock_carrier;
		logic fast_internal_oscillator;
	} source_bus_t;

	// one carrier control group
	typedef struct packed {
		logic invert;
		logic sync_enable;
		logic [3:0] select;
	} carrier_config_t;

	// software-visible configuration
	typedef struct packed {
		logic modulator_enable;
		logic output_invert;
		logic software_modulation_value;
		logic [3:0] data_source_select;
		carrier_config_t upper_carrier_reg;
		carrier_config_t lower_carrier_reg;
	} modulator_config_t;

	// all state of the modulator
	typedef struct packed {
		source_bus_t sync_first;
		source_bus_t sync_second;
		logic upper_prev;
		logic lower_prev;
		logic upper_active;
		logic lower_active;
		logic output_pin;
		logic status_first;
		logic status_second;
	} modulator_state_t;

	localparam modulator_state_t STATE_RESET = '0;

endpackage

/* File: hw/data_signal_modulator.sv */
// Function
// RULE_01: data high uses upper, low uses lower
// RULE_02: route internal or external selected sources
// RULE_03: disabled forces ground carriers, software data
// RULE_04: stored selections kept, reapplied on enable
// RULE_05: pin held low while disabled
// RULE_06: four-bit data source selection field
// RULE_07: serial data only usable in spi mode
// RULE_08: independent four-bit upper and lower selects
// RULE_09: leaving synced carrier waits its falling edge
// RULE_10: returning synced carrier waits its falling edge
// RULE_11: separate sync enable per carrier
// RULE_12: per-carrier polarity inversion before mixing
// RULE_13: software bit used as data when chosen
// RULE_14: output polarity bit inverts pin output
// RULE_15: keeps running in sleep, no gating
// RULE_16: reset disables module, clears state; here reset clears state only, modulator_enable comes from config_in untouched
// RULE_17: data codes decoded, reserved connect nothing
// RULE_18: carrier codes decoded, reserved connect nothing
// RULE_19: read-only status shows output value
// RULE_20: status passes two-stage synchroniser
module data_signal_modulator (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input modulator_pkg::modulator_config_t config_in,
	input wire logic serial_spi_mode_in,
	input modulator_pkg::source_bus_t sources_in,
	output logic modulated_output_out,
	output logic output_status_out
);
	import modulator_pkg::*;

	modulator_state_t state_reg;
	modulator_state_t state_next;

	// effective selections after the enable gate
	logic [3:0] data_code;
	logic [3:0] upper_code;
	logic [3:0] lower_code;
	logic data_bit;

	// carrier values after selection and polarity
	logic upper_raw;
	logic lower_raw;
	logic upper_carrier_signal;
	logic lower_carrier_signal;

	// falling edges and next activity
	logic upper_fell;
	logic lower_fell;
	logic upper_active_next;
	logic lower_active_next;
	logic mixed_value;

	// modulating data multiplexer
	function automatic logic select_data(
		input logic [3:0] code,
		input source_bus_t src,
		input logic soft_bit,
		input logic spi_mode
	);
		logic value;
		value = 1'b0;
		unique case (code)
			// RULE_13: software bit as data
			DATA_SOFTWARE: value = soft_bit;
			DATA_EXT_PIN: value = src.external_data_pin;
			DATA_CCP1: value = src.ccp1_output;
			DATA_CCP2: value = src.ccp2_output;
			DATA_PWM5: value = src.pwm5_output;
			DATA_PWM6: value = src.pwm6_output;
			DATA_CMP1: value = src.comparator1_output;
			DATA_CMP2: value = src.comparator2_output;
			// RULE_07: serial only in spi
			DATA_SERIAL: value = spi_mode & src.serial_data_out;
			DATA_UART_TX: value = src.uart_tx_output;
			DATA_NCO: value = src.nco_output;
			DATA_CLC1: value = src.clc1_output;
			DATA_CLC2: value = src.clc2_output;
			// RULE_17: reserved codes connect nothing
			default: value = 1'b0;
		endcase
		return value;
	endfunction

	// carrier multiplexer, shared by both carriers
	function automatic logic select_carrier(
		input logic [3:0] code,
		input source_bus_t src
	);
		logic value;
		value = 1'b0;
		unique case (code)
			CARRIER_GROUND: value = 1'b0;
			CARRIER_PIN_A: value = src.external_carrier_pin_a;
			CARRIER_PIN_B: value = src.external_carrier_pin_b;
			CARRIER_REF_CLOCK: value = src.reference_clock_output;
			CARRIER_CCP1: value = src.ccp1_output;
			CARRIER_CCP2: value = src.ccp2_output;
			CARRIER_PWM5: value = src.pwm5_output;
			CARRIER_PWM6: value = src.pwm6_output;
			CARRIER_NCO: value = src.nco_output;
			CARRIER_SYS_CLOCK: value = src.system_clock_carrier;
			CARRIER_FAST_OSC: value = src.fast_internal_oscillator;
			CARRIER_CLC1: value = src.clc1_output;
			CARRIER_CLC2: value = src.clc2_output;
			// RULE_18: reserved codes connect nothing
			default: value = 1'b0;
		endcase
		return value;
	endfunction

	// next activity of one carrier
	function automatic logic carrier_activity(
		input logic sync_enable,
		input logic wanted,
		input logic active,
		input logic fell
	);
		logic value;
		value = active;
		if (!sync_enable) begin
			// unsynchronised: follows data at once
			value = wanted;
		end else if (wanted != active) begin
			// synchronised: change only on a falling edge
			if (fell) begin
				value = wanted;
			end
		end
		return value;
	endfunction

	// enable gate on the stored selections
	always_comb begin
		// RULE_03: forced ground and software bit
		// RULE_04: stored fields untouched, reused on enable
		if (config_in.modulator_enable) begin
			data_code = config_in.data_source_select;
			upper_code = config_in.upper_carrier_reg.select;
			lower_code = config_in.lower_carrier_reg.select;
		end else begin
			data_code = DATA_SOFTWARE;
			upper_code = CARRIER_GROUND;
			lower_code = CARRIER_GROUND;
		end
	end

	// source selection from synchronised inputs
	always_comb begin
		// RULE_02: route selected source
		// RULE_06: four-bit data field
		data_bit = select_data(data_code, state_reg.sync_second,
			config_in.software_modulation_value, serial_spi_mode_in);
		// RULE_08: independent carrier fields
		upper_raw = select_carrier(upper_code, state_reg.sync_second);
		lower_raw = select_carrier(lower_code, state_reg.sync_second);
	end

	// carrier polarity
	always_comb begin
		// RULE_12: invert before mixing
		upper_carrier_signal = upper_raw ^ config_in.upper_carrier_reg.invert;
		lower_carrier_signal = lower_raw ^ config_in.lower_carrier_reg.invert;
	end

	// falling edges of the polarised carriers
	always_comb begin
		upper_fell = state_reg.upper_prev & ~upper_carrier_signal;
		lower_fell = state_reg.lower_prev & ~lower_carrier_signal;
	end

	// carrier activity tracking
	always_comb begin
		// RULE_11: per-carrier sync enables
		// RULE_09: leaving synced carrier holds it
		// RULE_10: returning synced carrier waits
		upper_active_next = carrier_activity(config_in.upper_carrier_reg.sync_enable,
			data_bit, state_reg.upper_active, upper_fell);
		lower_active_next = carrier_activity(config_in.lower_carrier_reg.sync_enable,
			~data_bit, state_reg.lower_active, lower_fell);
	end

	// mixing of the active carriers
	always_comb begin
		// RULE_01: upper while high, lower while low
		mixed_value = (upper_active_next & upper_carrier_signal) |
			(lower_active_next & lower_carrier_signal);
	end

	// next state
	always_comb begin
		state_next = state_reg;
		// two flip-flops on every asynchronous source
		state_next.sync_first = sources_in;
		state_next.sync_second = state_reg.sync_first;
		// edge history
		state_next.upper_prev = upper_carrier_signal;
		state_next.lower_prev = lower_carrier_signal;
		state_next.upper_active = upper_active_next;
		state_next.lower_active = lower_active_next;
		// RULE_05: pin low while disabled
		// RULE_14: output polarity inversion
		if (config_in.modulator_enable) begin
			state_next.output_pin = mixed_value ^ config_in.output_invert;
		end else begin
			state_next.output_pin = 1'b0;
		end
		// RULE_20: status through two stages
		// RULE_19: status follows output value
		state_next.status_first = state_reg.output_pin;
		state_next.status_second = state_reg.status_first;
	end

	// state register, free running
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		// RULE_16: reset clears all state
		// RULE_15: no sleep gating anywhere
		if (!rst_n_in) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from flip-flops
	assign modulated_output_out = state_reg.output_pin;
	assign output_status_out = state_reg.status_second;

endmodule

/* File: dv/source_model.sv */
module source_model (
	input wire logic clk_in,
	input modulator_pkg::source_bus_t pattern_in,
	output modulator_pkg::source_bus_t sources_out
);
	import modulator_pkg::*;
	logic [1:0] osc_reg = 2'h0;
	initial sources_out = '0;
	// peripheral and pin levels
	// levels move off the sampling edge; the two clock carriers run free
	always @(negedge clk_in) begin
		osc_reg <= osc_reg + 2'h1;
		sources_out <= pattern_in;
		sources_out.system_clock_carrier <= osc_reg[1];
		sources_out.fast_internal_oscillator <= osc_reg[0];
	end
endmodule

/* File: dv/data_signal_modulator_checker.sv */
module data_signal_modulator_checker (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input modulator_pkg::modulator_config_t config_in,
	input wire logic serial_spi_mode_in,
	input modulator_pkg::source_bus_t sources_in,
	input wire logic modulated_output_out,
	input wire logic output_status_out
);
	import modulator_pkg::*;
	logic [1:0] age_reg;
	logic en, oi, sb, gu, gl, lo1;
	logic [3:0] ds;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// edges since reset, saturating, so the pipeline is full
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
			age_reg <= 2'h0;
		else if (age_reg != 2'h3)
			age_reg <= age_reg + 2'h1;
	// shorthand for plain unsynced carrier setups
	assign en = config_in.modulator_enable;
	assign oi = config_in.output_invert;
	assign sb = config_in.software_modulation_value;
	assign ds = config_in.data_source_select;
	assign gu = config_in.upper_carrier_reg == 6'h00;
	assign gl = config_in.lower_carrier_reg == 6'h00;
	assign lo1 = en && gu && config_in.lower_carrier_reg == 6'h20;
	a_disabled_pin_low: assert property (!en |=> !modulated_output_out)
		else $error("pin high while disabled");
	a_ground_idle_level: assert property (en && gu && gl |=> modulated_output_out == $past(oi))
		else $error("idle level wrong");
	a_soft_bit_upper: assert property (en && ds == 4'h0 && config_in.upper_carrier_reg == 6'h20 && gl
		|=> modulated_output_out == $past(sb ^ oi))
		else $error("software bit not mixed");
	a_lower_invert_mix: assert property (lo1 && ds == 4'h0 |=> modulated_output_out == $past(!sb ^ oi))
		else $error("lower carrier mix wrong");
	a_reserved_data_none: assert property (lo1 && ds inside {4'h9, 4'hE, 4'hF}
		|=> modulated_output_out == !$past(oi))
		else $error("reserved data not zero");
	a_serial_needs_spi: assert property (lo1 && ds == DATA_SERIAL && !serial_spi_mode_in
		|=> modulated_output_out == !$past(oi))
		else $error("serial data passed outside spi");
	a_reserved_carrier_none: assert property (en && gl && config_in.upper_carrier_reg[5:4] == 2'h0
		&& config_in.upper_carrier_reg[3:0] inside {4'h9, 4'hE, 4'hF} |=> modulated_output_out == $past(oi))
		else $error("reserved carrier not zero");
	a_pin_a_routed: assert property (age_reg == 2'h3 && en && ds == 4'h0 && sb && gl
		&& config_in.upper_carrier_reg == 6'h01
		|=> modulated_output_out == ($past(sources_in.external_carrier_pin_a, 3) ^ $past(oi)))
		else $error("pin carrier not routed");
	a_status_two_behind: assert property (output_status_out == $past(modulated_output_out, 2))
		else $error("status not two behind");
	a_reset_clears_all: assert property ($rose(rst_n_in) |-> !modulated_output_out && !output_status_out)
		else $error("outputs not cleared");
	c_upper_sync: cover property (en && config_in.upper_carrier_reg.sync_enable && modulated_output_out);
	c_reenable: cover property (!en ##1 en);
	c_serial_spi: cover property (en && ds == DATA_SERIAL && serial_spi_mode_in);
endmodule

/* File: dv/test_data_signal_modulator.sv */
module test_data_signal_modulator;
	timeunit 1ns;
	timeprecision 1ps;
	import modulator_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic spi = 1'b0;
	modulator_config_t cfg = '0;
	source_bus_t pat = '0;
	source_bus_t src, s1, s2;
	logic out, st, ua, la, up, lp, mo, m1, m2, d, uc, lc, ua_n, la_n, en;
	logic [3:0] ds, us, ls;
	logic [31:0] rng = 32'hb05a_73da;
	int n_errors = 0;
	int compares = 0;
	int dp[16] = '{-1, 16, 12, 11, 10, 9, 8, 7, 6, -1, 5, 4, 3, 2, -1, -1};
	int cp[16] = '{-1, 15, 14, 13, 12, 11, 10, 9, 4, -1, 1, 0, 3, 2, -1, -1};
	always #12.5 clk_in = ~clk_in;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic pick(input source_bus_t s, input int p);
		return (p < 0) ? 1'b0 : s[p];
	endfunction
	// expected mix, disabled forces ground carriers and software data
	always_comb begin
		en = cfg.modulator_enable;
		ds = en ? cfg.data_source_select : 4'h0;
		us = en ? cfg.upper_carrier_reg.select : 4'h0;
		ls = en ? cfg.lower_carrier_reg.select : 4'h0;
		d = (ds == 4'h0) ? cfg.software_modulation_value : pick(s2, dp[ds]) & (ds != DATA_SERIAL || spi);
		uc = pick(s2, cp[us]) ^ cfg.upper_carrier_reg.invert;
		lc = pick(s2, cp[ls]) ^ cfg.lower_carrier_reg.invert;
		ua_n = (!cfg.upper_carrier_reg.sync_enable || (up && !uc)) ? d : ua;
		la_n = (!cfg.lower_carrier_reg.sync_enable || (lp && !lc)) ? !d : la;
	end
	// expected pipeline, sync flags and status delay
	always @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
			{s1, s2, up, lp, ua, la, mo, m1, m2} <= '0;
		else begin
			{s1, s2} <= {src, s1};
			{up, lp, ua, la} <= {uc, lc, ua_n, la_n};
			mo <= en & (((ua_n & uc) | (la_n & lc)) ^ cfg.output_invert);
			{m1, m2} <= {mo, m1};
		end
	task automatic check(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// phases of eight cycles: random setups with fixed corner setups among them
	initial begin
		for (int p = 0; p < 600; p++) begin
			rng = xs(rng);
			cfg = modulator_config_t'(rng[16:0]);
			spi = rng[17];
			case (p % 8)
				0: {cfg.upper_carrier_reg, cfg.lower_carrier_reg} = 12'h000;
				1: {cfg.data_source_select, cfg.upper_carrier_reg, cfg.lower_carrier_reg} = 16'h0800;
				2: {cfg.upper_carrier_reg, cfg.lower_carrier_reg} = 12'h020;
				3: {cfg.upper_carrier_reg[5:4], cfg.lower_carrier_reg} = 8'h00;
				4: {cfg.software_modulation_value, cfg.data_source_select, cfg.upper_carrier_reg,
					cfg.lower_carrier_reg} = 17'h1_0040;
				default: ;
			endcase
			if (p % 8 < 5)
				cfg.modulator_enable = 1'b1;
			for (int c = 0; c < 8; c++) begin
				@(negedge clk_in);
				check(out, mo);
				check(st, m2);
				rst_n_in = !((p == 0 || p == 300) && c < 2);
				if (p % 8 == 4)
					cfg.modulator_enable = (c < 2 || c > 4);
				rng = xs(rng);
				pat = source_bus_t'(rng[16:0]);
			end
		end
		report_and_stop();
	end
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
	source_model partner (.clk_in(clk_in), .pattern_in(pat), .sources_out(src));
	data_signal_modulator DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .config_in(cfg),
		.serial_spi_mode_in(spi), .sources_in(src), .modulated_output_out(out), .output_status_out(st));
endmodule
bind data_signal_modulator data_signal_modulator_checker chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.config_in(config_in), .serial_spi_mode_in(serial_spi_mode_in), .sources_in(sources_in),
	.modulated_output_out(modulated_output_out), .output_status_out(output_status_out));
